// ===== rtl/lciau_pkg.sv
package lciau_pkg;

  // Clock and timing.
  localparam int  CLK_HZ        = 10_000_000;
  localparam int  CLK_NS        = 100;
  localparam real BLINK_SMALL_MS = 409.6;
  localparam real BLINK_LARGE_MS = 614.4;
  localparam int  BLINK_SMALL_CYC = int'(BLINK_SMALL_MS * CLK_HZ / 1000.0);
  localparam int  BLINK_LARGE_CYC = int'(BLINK_LARGE_MS * CLK_HZ / 1000.0);
  localparam int  BUSY_NS       = 1000;
  localparam int  LINE_NS       = 20000;
  localparam int  BUSY_CYC      = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int  LINE_CYC      = (LINE_NS + CLK_NS - 1) / CLK_NS;
  localparam int  BUSY_W        = 8;
  localparam int  LINE_W        = 12;

  // Widths and memory sizes.
  localparam int DATA_W   = 8;
  localparam int DD_DEPTH = 160;
  localparam int CG_DEPTH = 32;
  localparam int CG_AW    = 5;
  localparam int UL_BIT   = 8;
  localparam logic [7:0] DD_LINE_LEN = 8'h28;
  localparam logic [7:0] LINE_STRIDE = 8'h40;
  localparam logic [7:0] RST_AC      = 8'h00;

  // Register select codes on the two select lines.
  localparam logic [1:0] SEL_INSTR = 2'h0;
  localparam logic [1:0] SEL_DATA  = 2'h1;
  localparam logic [1:0] SEL_ADDR  = 2'h2;
  localparam logic [1:0] SEL_STAT  = 2'h3;

  // Instruction opcode bits, highest set bit wins.
  localparam int OP_DC = 7;
  localparam int OP_FS = 6;
  localparam int OP_CG = 5;
  localparam int OP_MV = 4;
  localparam int OP_EM = 3;

  // Field positions inside instructions.
  localparam int DC_ON  = 6;
  localparam int DC_CUR = 5;
  localparam int DC_BLK = 4;
  localparam int DC_UC  = 3;
  localparam int DC_UB  = 2;
  localparam int FS_N   = 5;
  localparam int FS_F1  = 3;
  localparam int MV_SC  = 3;
  localparam int MV_UD  = 2;
  localparam int MV_D2  = 1;
  localparam int MV_D1  = 0;
  localparam int EM_ID  = 2;
  localparam int EM_S   = 1;
  localparam int EM_AO  = 0;

  typedef enum logic {LCIAU_IDLE, LCIAU_BUSY} lciau_state_t;

  // Whole control state of the instruction unit.
  typedef struct packed {
    lciau_state_t        state;
    logic [BUSY_W-1:0]   busy_cnt;
    logic [LINE_W-1:0]   line_cnt;
    logic [1:0]          pend_line;
    logic [1:0]          start_line;
    logic                display_on;
    logic                cursor_on;
    logic                cursor_blink;
    logic                underline_cursor;
    logic                underline_blink;
    logic                font_large;
    logic                four_line;
    logic                inc;
    logic                shift_en;
    logic                cg_enable;
    logic                counter_target;
    logic [7:0]          ac;
    logic [7:0]          rd_buf;
    logic [7:0]          ul_buf;
    logic [7:0]          dout;
    logic                shl;
    logic                shr;
  } lciau_ctrl_t;

endpackage : lciau_pkg

// ===== rtl/lciau_blink_if.sv
`timescale 1ns/10ps
// Carries the blink request and the blink phase between the unit and its timer.
interface lciau_blink_if;
  logic enable;
  logic large_font;
  logic phase;
  modport timer (input enable, input large_font, output phase);
  modport user  (output enable, output large_font, input phase);
endinterface : lciau_blink_if

// ===== rtl/lciau_blink_timer.sv
`timescale 1ns/10ps
module lciau_blink_timer #(
  parameter int SMALL_CYC = lciau_pkg::BLINK_SMALL_CYC,
  parameter int LARGE_CYC = lciau_pkg::BLINK_LARGE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Blink control and phase.
  lciau_blink_if.timer bl
);
  import lciau_pkg::*;

  logic [31:0] count;
  logic [31:0] next_count;
  logic        phase;
  logic        next_phase;
  logic [31:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // The half period follows the font; stopping the blink returns to normal.
  always_comb begin
    limit      = bl.large_font ? 32'(LARGE_CYC - 1) : 32'(SMALL_CYC - 1);
    next_count = count + 32'h1;
    next_phase = phase;
    if (!bl.enable) begin
      next_count = 32'h0;
      next_phase = 1'b0;
    end else if (count >= limit) begin
      next_count = 32'h0;
      next_phase = ~phase;
    end
  end

  // Registers the timer state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 32'h0;
      phase <= 1'b0;
    end else begin
      count <= next_count;
      phase <= next_phase;
    end
  end

  assign bl.phase = phase;

endmodule : lciau_blink_timer

// ===== rtl/lciau_instruction_access_unit.sv
// Functional notes
// R1: Cursor shown while cursor bit high.
// R2: Cursor blink alternates, period set by font.
// R3: All four display attributes combine freely.
// R4: Underline at cursor while underline bit high.
// R5: Underline blink blinks the underlined character.
// R6: Data write stores eight bits to target.
// R7: Write steps address, shifts display if enabled.
// R8: Address set loads counter, targets display RAM.
// R9: Host keeps display addresses inside valid ranges.
// R10: Underline read: bit 7 underline, low seven data.
// R11: First underline read invalid, then valid.
// R12: Underline read steps address, never shifts.
// R13: Data read returns eight bits from target.
// R14: Host sets address right before data reads.
// R15: Cursor shift makes first display read valid.
// R16: Data read steps address, never shifts.
// R17: Address read returns shared address counter.
// R18: Busy one ignores instructions, hides low bits.
// R19: Host polls busy one before each instruction.
// R20: Busy two mirrors busy one except start line.
// R21: Newer start line replaces pending one.
// R22: Idle status shows target and mode bits.
// R23: Entry direction bit picks increment or decrement.
// R24: Select lines and direction choose access kind.
`timescale 1ns/10ps
module lciau_instruction_access_unit #(
  parameter int BLINK_SMALL_CYCLES = lciau_pkg::BLINK_SMALL_CYC,
  parameter int BLINK_LARGE_CYCLES = lciau_pkg::BLINK_LARGE_CYC
) (
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // Host parallel bus pins.
  input  wire logic                           register_select_hi,
  input  wire logic                           register_select_lo,
  input  wire logic                           rw_read,
  input  wire logic                           strobe,
  input  wire logic [lciau_pkg::DATA_W-1:0]   db_in,
  output logic      [lciau_pkg::DATA_W-1:0]   db_out,
  output logic                                db_oe,
  // Busy indications.
  output logic                                busy_one_flag,
  output logic                                busy_two_flag,
  // Display attributes toward the LCD timing logic.
  output logic                                display_on,
  output logic                                cursor_visible,
  output logic                                cursor_all_dots,
  output logic                                underline_visible,
  output logic                                underline_char_off,
  output logic [7:0]                          cursor_addr,
  output logic [1:0]                          start_line,
  output logic                                four_line_mode,
  output logic                                large_font,
  output logic                                display_shift_left,
  output logic                                display_shift_right
);
  import lciau_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strobe edge detect.

  logic [11:0] pin_meta;
  logic [11:0] pin_sync;
  logic        strobe_last;
  logic        take;
  logic        rd;
  logic [1:0]  sel;
  logic [7:0]  wd;

  // Two flops for every pin before any logic looks at it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta    <= 12'h000;
      pin_sync    <= 12'h000;
      strobe_last <= 1'b0;
    end else begin
      pin_meta    <= {strobe, rw_read, register_select_hi, register_select_lo, db_in};
      pin_sync    <= pin_meta;
      strobe_last <= pin_sync[11];
    end
  end

  // An access is taken once, on the rising edge of the synced strobe.
  assign take = pin_sync[11] & ~strobe_last;
  assign rd   = pin_sync[10];
  assign sel  = pin_sync[9:8];
  assign wd   = pin_sync[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Character memories.

  logic [8:0]       ddram [DD_DEPTH];
  logic [7:0]       cgram [CG_DEPTH];
  logic             we_dd;
  logic             we_cg;
  logic [7:0]       w_idx;
  logic [8:0]       w_word;

  // Maps a line/column address onto the packed display memory.
  function automatic logic [7:0] dd_index(input logic [7:0] a);
    logic [7:0] line;
    line = {6'h00, a[7:6]};
    dd_index = 8'(line * DD_LINE_LEN + {2'h0, a[5:0]});
  endfunction : dd_index

  // Columns beyond the line length are holes the host never addresses.
  function automatic logic dd_valid(input logic [7:0] a);
    dd_valid = ({2'h0, a[5:0]} < DD_LINE_LEN); // see R9
  endfunction : dd_valid

  // Reads the word at an address in the selected memory.
  function automatic logic [8:0] ram_word(input logic [7:0] a, input logic cg);
    ram_word = 9'h000;
    if (cg) begin
      ram_word = {1'b0, cgram[a[CG_AW-1:0]]};
    end else if (dd_valid(a)) begin
      ram_word = ddram[dd_index(a)];
    end
  endfunction : ram_word

  // Steps the address by one; the character memory wraps on its own width.
  function automatic logic [7:0] step(input logic [7:0] a, input logic up, input logic cg);
    logic [7:0] s;
    s = up ? a + 8'h01 : a - 8'h01; // see R23
    step = cg ? {3'h0, s[CG_AW-1:0]} : s;
  endfunction : step

  ////////////////////////////////////////////////////////////////////////////
  // Instruction execution.

  lciau_ctrl_t c;
  lciau_ctrl_t n;
  logic [7:0]  status;
  logic [7:0]  nxt;
  logic [7:0]  mv;
  logic [8:0]  cur_word;

  // Status word; the low six bits read zero while busy one is high.
  always_comb begin
    status = {busy_one_flag, busy_two_flag, 6'h00};
    if (c.state == LCIAU_IDLE) begin
      status[5:0] = {c.counter_target, c.inc, c.shift_en, c.cg_enable,
                     c.display_on, c.underline_cursor | c.underline_blink}; // see R22
    end
  end // see R18

  // Computes the next control state and any memory write.
  always_comb begin
    n      = c;
    n.shl  = 1'b0;
    n.shr  = 1'b0;
    we_dd  = 1'b0;
    we_cg  = 1'b0;
    w_idx  = 8'h00;
    w_word = 9'h000;
    nxt    = step(c.ac, c.inc, c.counter_target);
    mv     = 8'h00;
    cur_word = ram_word(c.ac, c.counter_target);
    // Busy one counts down the execution time of the last instruction.
    if (c.state == LCIAU_BUSY) begin
      n.busy_cnt = c.busy_cnt - BUSY_W'(1);
      if (c.busy_cnt == BUSY_W'(1)) begin
        n.state = LCIAU_IDLE;
      end
    end
    // Start line revision finishes by applying the newest value.
    if (c.line_cnt != '0) begin
      n.line_cnt = c.line_cnt - LINE_W'(1);
      if (c.line_cnt == LINE_W'(1)) begin
        n.start_line = c.pend_line;
      end
    end
    if (take && rd && sel == SEL_STAT) begin
      n.dout = status; // see R24
    end else if (take && c.state == LCIAU_IDLE) begin // see R18
      n.state    = LCIAU_BUSY;
      n.busy_cnt = BUSY_W'(BUSY_CYC);
      case ({rd, sel}) // see R24
        {1'b0, SEL_INSTR}: begin
          if (wd[OP_DC]) begin
            n.display_on       = wd[DC_ON];
            n.cursor_on        = wd[DC_CUR]; // see R1
            n.cursor_blink     = wd[DC_BLK]; // see R2
            n.underline_cursor = wd[DC_UC];  // see R4
            n.underline_blink  = wd[DC_UB];  // see R5
          end else if (wd[OP_FS]) begin
            n.four_line  = wd[FS_N];
            n.font_large = wd[FS_F1];
          end else if (wd[OP_CG]) begin
            n.ac             = {3'h0, wd[CG_AW-1:0]};
            n.counter_target = 1'b1;
            n.rd_buf         = 8'(ram_word({3'h0, wd[CG_AW-1:0]}, 1'b1));
          end else if (wd[OP_MV]) begin
            if (!wd[MV_SC]) begin
              // Cursor shift; a fresh prefetch keeps the next read valid.
              if (!wd[MV_UD]) begin
                mv = step(c.ac, wd[MV_D2], c.counter_target);
              end else begin
                mv = wd[MV_D2] ? c.ac - LINE_STRIDE : c.ac + LINE_STRIDE;
              end
              n.ac     = mv;
              n.rd_buf = 8'(ram_word(mv, c.counter_target)); // see R15
            end else if (!wd[MV_UD]) begin
              n.shr = wd[MV_D2];
              n.shl = ~wd[MV_D2];
            end else begin
              // A newer start line restarts the revision and wins.
              n.pend_line = c.four_line ? {wd[MV_D2], wd[MV_D1]} : {1'b0, wd[MV_D1]};
              n.line_cnt  = LINE_W'(LINE_CYC); // see R21
            end
          end else if (wd[OP_EM]) begin
            n.inc       = wd[EM_ID];
            n.shift_en  = wd[EM_S];
            n.cg_enable = wd[EM_AO];
          end
        end
        {1'b0, SEL_DATA}: begin
          // The stored underline bit follows the underline setting.
          if (c.counter_target) begin
            we_cg = 1'b1;
            w_idx = {3'h0, c.ac[CG_AW-1:0]};
          end else begin
            we_dd = dd_valid(c.ac); // see R9
            w_idx = dd_index(c.ac);
          end
          w_word = {c.underline_cursor, wd}; // see R6
          n.ac   = nxt; // see R7
          if (!c.counter_target && c.shift_en) begin
            n.shl = c.inc;
            n.shr = ~c.inc;
          end
        end
        {1'b1, SEL_INSTR}: begin
          // Returns the word fetched by the previous read, so the first one is stale.
          n.dout   = c.ul_buf; // see R11
          n.ac     = nxt; // see R12
          n.ul_buf = {cur_word[UL_BIT], cur_word[6:0]}; // see R10
        end
        {1'b1, SEL_DATA}: begin
          n.dout   = c.rd_buf; // see R13
          n.ac     = nxt; // see R16
          n.rd_buf = 8'(ram_word(nxt, c.counter_target)); // see R14
        end
        {1'b0, SEL_ADDR}: begin
          n.ac             = wd;
          n.counter_target = 1'b0; // see R8
          n.rd_buf         = 8'(ram_word(wd, 1'b0));
        end
        {1'b1, SEL_ADDR}: begin
          n.dout = c.ac; // see R17
        end
        default: begin
          n.state    = c.state;
          n.busy_cnt = c.busy_cnt;
        end
      endcase
    end
  end

  // Registers the control state; reset sets increment mode and the reset address.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c      <= '0;
      c.inc  <= 1'b1;
      c.ac   <= RST_AC;
      c.state <= LCIAU_IDLE;
    end else begin
      c <= n;
    end
  end

  // Memory writes carry no reset.
  always_ff @(posedge clk) begin
    if (we_dd) begin
      ddram[w_idx] <= w_word;
    end
    if (we_cg) begin
      cgram[w_idx[CG_AW-1:0]] <= w_word[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink timer and display attributes.

  lciau_blink_if blink ();

  // One timer serves both blinks so they stay in step.
  assign blink.enable     = c.cursor_blink | c.underline_blink;
  assign blink.large_font = c.font_large;

  lciau_blink_timer #(
    .SMALL_CYC (BLINK_SMALL_CYCLES),
    .LARGE_CYC (BLINK_LARGE_CYCLES)
  ) u_blink (
    .clk  (clk),
    .rstn (rstn),
    .bl   (blink)
  ); // see R2
  logic [4:0] attr;
  logic [4:0] next_attr;

  // Each attribute is decoded on its own so any mix is possible.
  always_comb begin
    next_attr[0] = c.display_on;
    next_attr[1] = c.display_on & c.cursor_on; // see R1
    next_attr[2] = c.display_on & c.cursor_blink & blink.phase; // see R2
    next_attr[3] = c.display_on & c.underline_cursor; // see R4
    next_attr[4] = c.display_on & c.underline_blink & blink.phase; // see R5
  end // see R3

  // Registers the attributes toward the display side.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      attr <= 5'h00;
    end else begin
      attr <= next_attr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Busy two stays up through a start line revision.
  assign busy_one_flag       = (c.state == LCIAU_BUSY);
  assign busy_two_flag       = busy_one_flag | (c.line_cnt != '0); // see R20
  assign db_out              = c.dout;
  assign db_oe               = strobe_last & rd;
  assign display_on          = attr[0];
  assign cursor_visible      = attr[1];
  assign cursor_all_dots     = attr[2];
  assign underline_visible   = attr[3];
  assign underline_char_off  = attr[4];
  assign cursor_addr         = c.ac;
  assign start_line          = c.start_line;
  assign four_line_mode      = c.four_line;
  assign large_font          = c.font_large;
  assign display_shift_left  = c.shl;
  assign display_shift_right = c.shr;
endmodule : lciau_instruction_access_unit

// ===== tb/lciau_props.sv
`timescale 1ns/10ps
// Watches the unit's pins for flag, pulse and attribute relations.
module lciau_props #(
  parameter int BLINK_SMALL_CYCLES = 8,
  parameter int BLINK_LARGE_CYCLES = 12
) (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rstn,
  // Busy flags.
  input wire logic       busy_one_flag,
  input wire logic       busy_two_flag,
  // Display attributes.
  input wire logic       display_on,
  input wire logic       cursor_visible,
  input wire logic       underline_visible,
  input wire logic       underline_char_off,
  input wire logic [7:0] cursor_addr,
  input wire logic [1:0] start_line,
  input wire logic       display_shift_left,
  input wire logic       display_shift_right
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  // Attributes are only shown while the display is enabled.
  chk_cursor_gate: assert property (cursor_visible |-> display_on)
    else $error("cursor shown while display is off");
  chk_uline_gate: assert property (underline_visible |-> display_on)
    else $error("underline shown while display is off");
  // Busy one lasts exactly ten cycles and busy two always covers it.
  chk_busy_len: assert property ($rose(busy_one_flag) |-> busy_one_flag[*5] ##1
    busy_one_flag[*5] ##1 !busy_one_flag)
    else $error("busy one length is not ten cycles");
  chk_busy_mirror: assert property (busy_one_flag |-> busy_two_flag)
    else $error("busy two low while busy one high");
  // Address and shift changes only come with an accepted access.
  chk_ac_steps: assert property ($changed(cursor_addr) |-> $rose(busy_one_flag))
    else $error("address counter moved without an access");
  chk_shift_busy: assert property ((display_shift_left || display_shift_right)
    |-> $rose(busy_one_flag))
    else $error("display shift without an access");
  chk_shift_excl: assert property (!(display_shift_left && display_shift_right))
    else $error("display shifted both ways at once");
  chk_shift_pulse: assert property (display_shift_left |=> !display_shift_left)
    else $error("left shift pulse longer than one cycle");
  // The start line only moves at the end of a revision.
  chk_start_quiet: assert property (!$past(busy_two_flag) |-> $stable(start_line))
    else $error("start line changed outside a revision");

  // Main scenarios reached.
  cover property ($fell(busy_one_flag) && busy_two_flag);
  cover property (display_shift_right);
  cover property ($rose(underline_char_off));
  cover property ($changed(start_line));
endmodule : lciau_props

bind lciau_instruction_access_unit lciau_props #(
  .BLINK_SMALL_CYCLES(BLINK_SMALL_CYCLES),
  .BLINK_LARGE_CYCLES(BLINK_LARGE_CYCLES)
) i_lciau_props (
  .clk(clk), .rstn(rstn), .busy_one_flag(busy_one_flag), .busy_two_flag(busy_two_flag),
  .display_on(display_on), .cursor_visible(cursor_visible),
  .underline_visible(underline_visible), .underline_char_off(underline_char_off),
  .cursor_addr(cursor_addr), .start_line(start_line),
  .display_shift_left(display_shift_left), .display_shift_right(display_shift_right)
);

// ===== tb/lciau_host.sv
`timescale 1ns/10ps
// Host microcontroller model: one parallel bus access at a time.
module lciau_host (
  // Clock.
  input  wire logic       clk,
  // Host bus pins.
  output logic            register_select_hi,
  output logic            register_select_lo,
  output logic            rw_read,
  output logic            strobe,
  output logic [7:0]      db_in,
  input  wire logic [7:0] db_out
);
  // Bus idles with the strobe low.
  initial begin
    {rw_read, register_select_hi, register_select_lo} = 3'h0;
    strobe = 1'b0;
    db_in = 8'h00;
  end

  // Holds the access for six cycles, samples the answer, then keeps strobe low.
  task automatic acc(input logic [2:0] kind, input logic [7:0] wd, output logic [7:0] rd);
    @(negedge clk);
    {rw_read, register_select_hi, register_select_lo} = kind;
    db_in = wd;
    strobe = 1'b1;
    repeat (6) @(negedge clk);
    rd = db_out;
    strobe = 1'b0;
    db_in = ~wd; // Released lines do not keep the last value.
    repeat (2) @(negedge clk);
  endtask : acc

  // Polls the status word until busy one reads low.
  task automatic ready();
    logic [7:0] s;
    s = 8'h80;
    for (int i = 0; i < 50 && s[7] !== 1'b0; i++) acc(3'h7, 8'h00, s);
  endtask : ready
endmodule : lciau_host

// ===== tb/tb_lciau_instruction_access_unit.sv
`timescale 1ns/10ps
// Bench for the instruction access unit, driven through the host model.
module tb_lciau_instruction_access_unit;
  localparam logic [2:0] K_INS = 3'h0;
  localparam logic [2:0] K_WR  = 3'h1;
  localparam logic [2:0] K_ADR = 3'h2;
  localparam logic [2:0] K_ULR = 3'h4;
  localparam logic [2:0] K_RD  = 3'h5;
  localparam logic [2:0] K_AC  = 3'h6;
  localparam logic [2:0] K_ST  = 3'h7;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       register_select_hi, register_select_lo, rw_read, strobe, db_oe;
  logic [7:0] db_in, db_out, cursor_addr, r;
  logic       busy_one_flag, busy_two_flag, display_on, cursor_visible, cursor_all_dots;
  logic       underline_visible, underline_char_off, four_line_mode, large_font;
  logic       display_shift_left, display_shift_right;
  logic       saw_one = 1'b0;
  logic       oe_wr = 1'b0;
  int         n_oe = 0;
  logic [1:0] start_line;
  int         fails = 0;
  int         n_compared = 0;
  int         n_shl = 0;
  int         n_shr = 0;
  int         f;

  always #50 clk = ~clk;

  lciau_instruction_access_unit #(.BLINK_SMALL_CYCLES(8), .BLINK_LARGE_CYCLES(12))
  i_lciau_instruction_access_unit (
    .clk(clk), .rstn(rstn), .register_select_hi(register_select_hi),
    .register_select_lo(register_select_lo), .rw_read(rw_read), .strobe(strobe),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .busy_one_flag(busy_one_flag),
    .busy_two_flag(busy_two_flag), .display_on(display_on), .cursor_visible(cursor_visible),
    .cursor_all_dots(cursor_all_dots), .underline_visible(underline_visible),
    .underline_char_off(underline_char_off), .cursor_addr(cursor_addr),
    .start_line(start_line), .four_line_mode(four_line_mode), .large_font(large_font),
    .display_shift_left(display_shift_left), .display_shift_right(display_shift_right));

  lciau_host i_lciau_host (
    .clk(clk), .register_select_hi(register_select_hi),
    .register_select_lo(register_select_lo), .rw_read(rw_read), .strobe(strobe),
    .db_in(db_in), .db_out(db_out));

  ////////////////////////////////////////////////////////////////////////////////
  // Counts shift pulses and notes any appearance of start line one.
  always @(posedge clk) begin
    if (display_shift_left === 1'b1) n_shl++;
    if (display_shift_right === 1'b1) n_shr++;
    if (rstn && start_line === 2'h1) saw_one = 1'b1;
    if (db_oe === 1'b1) n_oe++;
    if (db_oe === 1'b1 && rw_read === 1'b0) oe_wr = 1'b1;
  end

  // Compares one byte result.
  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : chk8

  // Waits for busy one low, then makes one access.
  task automatic op(input logic [2:0] k, input logic [7:0] v, output logic [7:0] rd);
    i_lciau_host.ready();
    i_lciau_host.acc(k, v, rd);
  endtask : op

  // Counts changes of a blink phase output over n clocks.
  task automatic flips(input logic ul, input int n, output int cnt);
    logic p;
    p = ul ? underline_char_off : cursor_all_dots;
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((ul ? underline_char_off : cursor_all_dots) !== p) cnt++;
      p = ul ? underline_char_off : cursor_all_dots;
    end
  endtask : flips

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hung run short.
  initial begin
    #3_000_000;
    fails++;
    end_sim();
  end

  // Main sequence of host accesses.
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    op(K_ST, 8'h00, r);
    chk8(r, 8'h10);
    for (int v = 0; v < 32; v++) begin
      op(K_INS, 8'h80 | 8'(v << 2), r);
      op(K_ST, 8'h00, r);
      chk8(r, {6'h04, v[4], v[1] | v[0]});
      chk8({7'h00, cursor_visible}, {7'h00, v[4] & v[3]});
      chk8({7'h00, underline_visible}, {7'h00, v[4] & v[1]});
    end
    op(K_INS, 8'hD0, r);
    flips(1'b0, 80, f);
    chk8(8'(f), 8'h0A);
    op(K_INS, 8'h68, r);
    flips(1'b0, 96, f);
    chk8(8'(f), 8'h08);
    chk8({6'h00, four_line_mode, large_font}, 8'h03);
    op(K_INS, 8'hC4, r);
    flips(1'b1, 96, f);
    chk8(8'(f), 8'h08);
    flips(1'b0, 48, f);
    chk8(8'(f), 8'h00);
    op(K_INS, 8'hC8, r);
    op(K_ADR, 8'hC0, r);
    op(K_WR, 8'hAA, r);
    op(K_WR, 8'h55, r);
    op(K_AC, 8'h00, r);
    chk8(r, 8'hC2);
    chk8(cursor_addr, 8'hC2);
    op(K_ADR, 8'hC0, r);
    op(K_RD, 8'h00, r);
    chk8(r, 8'hAA);
    op(K_RD, 8'h00, r);
    chk8(r, 8'h55);
    op(K_ADR, 8'hC0, r);
    op(K_ULR, 8'h00, r);
    op(K_ULR, 8'h00, r);
    chk8(r, 8'hAA);
    op(K_ULR, 8'h00, r);
    chk8(r, 8'hD5);
    op(K_AC, 8'h00, r);
    chk8(r, 8'hC3);
    op(K_INS, 8'h10, r);
    op(K_INS, 8'h10, r);
    op(K_RD, 8'h00, r);
    chk8(r, 8'h55);
    op(K_INS, 8'h0A, r);
    op(K_ADR, 8'hC5, r);
    op(K_WR, 8'h11, r);
    chk8(cursor_addr, 8'hC4);
    chk8({n_shl[3:0], n_shr[3:0]}, 8'h01);
    op(K_ADR, 8'hC5, r);
    op(K_RD, 8'h00, r);
    chk8(r, 8'h11);
    chk8({n_shl[3:0], n_shr[3:0]}, 8'h01);
    op(K_INS, 8'h16, r);
    chk8(cursor_addr, 8'h84);
    op(K_ST, 8'h00, r);
    chk8(r, 8'h0B);
    op(K_INS, 8'h0D, r);
    op(K_INS, 8'h23, r);
    op(K_WR, 8'h3C, r);
    op(K_AC, 8'h00, r);
    chk8(r, 8'h04);
    op(K_ST, 8'h00, r);
    chk8(r, 8'h37);
    op(K_INS, 8'h23, r);
    op(K_RD, 8'h00, r);
    chk8(r, 8'h3C);
    chk8({n_shl[3:0], n_shr[3:0]}, 8'h01);
    op(K_INS, 8'h18, r);
    op(K_INS, 8'h1A, r);
    chk8({n_shl[3:0], n_shr[3:0]}, 8'h12);
    op(K_INS, 8'hC8, r);
    i_lciau_host.acc(K_ST, 8'h00, r);
    chk8(r, 8'hC0);
    op(K_INS, 8'hC8, r);
    i_lciau_host.acc(K_INS, 8'h80, r);
    op(K_ST, 8'h00, r);
    chk8({7'h00, display_on}, 8'h01);
    op(K_INS, 8'h1D, r);
    op(K_ST, 8'h00, r);
    chk8(r, 8'h77);
    op(K_INS, 8'h1F, r);
    repeat (260) @(negedge clk);
    chk8({6'h00, start_line}, 8'h03);
    chk8({7'h00, saw_one}, 8'h00);
    chk8({7'h00, oe_wr}, 8'h00);
    chk8({7'h00, n_oe > 0}, 8'h01);
    end_sim();
  end
endmodule : tb_lciau_instruction_access_unit
